/* acs_sequencer.sv */
`timescale 1ns/100ps
// Purpose: successive-approximation conversion sequencer with register port
// Assumes: cmp_in and trig_in are asynchronous pins, sleep_halt is on clk_sys
// Notes: registers are 8 bits wide at addresses 0..4
//
// Notes on behaviour
// - prescaler counts while enabled and is held in reset while disabled
// - a written start begins conversion at the next conversion clock rise
// - a normal conversion lasts 13 conversion clock cycles
// - the first conversion after enabling lasts 25 conversion clock cycles
// - sample at 1.5 cycles normally, 13.5 cycles on the first conversion
// - at completion write result, set done flag, clear start in single mode
// - a trigger resets the prescaler; sample two cycles after the trigger edge
// - three system cycles of trigger synchronisation are added
// - free running starts the next conversion at completion while start is set
// - selections copy to the active set until a start, then lock
// - copying resumes in the last conversion clock cycle
// - in free running the already started conversion keeps the old channel
// - inputs above the reference give codes close to full scale
// - a halt in quiet sleep starts a conversion when set up for it
// - the completion request is raised even if the core woke earlier
// - sleep never clears the enable bit by itself
// - low byte read blocks result updates until the high byte read
// - trigger edges during a conversion and held triggers are ignored
module acs_sequencer import acs_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   // trigger pin and core sleep status
   input wire logic trig_in,
   input wire logic sleep_halt,
   // analog core
   input wire logic cmp_in,
   output logic sample_hold,
   output logic [9:0] dac_code,
   output logic [3:0] channel_select,
   output logic [1:0] reference_select,
   output logic analog_on,
   // completion request
   output logic conv_irq
);
   typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_t;

   acs_presc_if pif();
   acs_prescaler u_presc (.clk_sys(clk_sys), .rst(rst), .pif(pif));

   acs_state_t state_q;
   logic converter_enable_q;
   logic start_conversion_q;
   logic auto_trigger_enable_q;
   logic conversion_done_flag_q;
   logic irq_enable_q;
   logic [2:0] clock_divide_select_q;
   logic [7:0] channel_reference_select_reg_q;
   logic free_run_q;
   logic first_q;
   logic auto_conv_q;
   logic [5:0] hc_q;
   logic [9:0] sar_q;
   logic [9:0] bit_q;
   logic sampled_q;
   logic [9:0] result_q;
   logic block_q;
   logic [7:0] rdata_q;
   logic sh_q;
   logic [3:0] ch_q;
   logic [1:0] ref_q;
   logic irq_q;
   logic cmp_s1_q, cmp_s2_q;
   logic trg_s1_q, trg_s2_q, trg_s3_q;
   logic halt_q;
   logic [5:0] total_h, sample_h;
   logic start_now, trig_edge, halt_start, done_now, last_cycle, sw_clear_done;
   logic conv_start, free_restart;

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   // two flops per pin; the third trigger flop gives the edge, three cycles
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
         trg_s1_q <= 1'b0;
         trg_s2_q <= 1'b0;
         trg_s3_q <= 1'b0;
         halt_q <= 1'b0;
      end else begin
         cmp_s1_q <= cmp_in;
         cmp_s2_q <= cmp_s1_q;
         trg_s1_q <= trig_in;
         trg_s2_q <= trg_s1_q;
         trg_s3_q <= trg_s2_q;
         halt_q <= sleep_halt;
      end
   end

   // ----------------------------------------
   // start decisions
   // ----------------------------------------
   // only a rising edge counts, so a trigger held high never restarts
   assign trig_edge = trg_s2_q && !trg_s3_q && auto_trigger_enable_q && !free_run_q
                      && converter_enable_q && state_q == ACS_IDLE;
   assign halt_start = sleep_halt && !halt_q && converter_enable_q && state_q == ACS_IDLE
                       && !auto_trigger_enable_q && irq_enable_q;
   assign start_now = start_conversion_q && pif.rise && state_q == ACS_IDLE;
   assign conv_start = start_now || trig_edge;
   assign total_h = first_q ? FIRST_TOTAL_H : (auto_conv_q ? AUTO_TOTAL_H : NORM_TOTAL_H);
   assign sample_h = first_q ? FIRST_SAMPLE_H : (auto_conv_q ? AUTO_SAMPLE_H : NORM_SAMPLE_H);
   assign done_now = state_q == ACS_CONV && pif.tick && hc_q == total_h - 6'h01;
   assign last_cycle = state_q == ACS_CONV && hc_q >= total_h - 6'h02;
   assign free_restart = done_now && free_run_q && auto_trigger_enable_q
                         && start_conversion_q;
   assign sw_clear_done = reg_we && reg_addr == ADDR_CTRL && reg_wdata[CTL_DONE];

   assign pif.en = converter_enable_q;
   assign pif.clr = trig_edge;
   assign pif.sel = clock_divide_select_q;

   // ----------------------------------------
   // control register
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         converter_enable_q <= 1'b0;
         auto_trigger_enable_q <= 1'b0;
         irq_enable_q <= 1'b0;
         clock_divide_select_q <= 3'h0;
         free_run_q <= 1'b0;
         channel_reference_select_reg_q <= RST_BYTE;
      end else if (reg_we) begin
         // sleep has no path here, so enable only changes by software
         if (reg_addr == ADDR_CTRL) begin
            converter_enable_q <= reg_wdata[CTL_EN];
            auto_trigger_enable_q <= reg_wdata[CTL_ATE];
            irq_enable_q <= reg_wdata[CTL_IE];
            clock_divide_select_q <= reg_wdata[2:0];
         end
         if (reg_addr == ADDR_SEL) begin
            channel_reference_select_reg_q <= reg_wdata;
         end
         if (reg_addr == ADDR_TRIG) begin
            free_run_q <= reg_wdata[TRG_FREE];
         end
      end
   end

   // ----------------------------------------
   // start bit
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         start_conversion_q <= 1'b0;
      end else if (!converter_enable_q
                   && !(reg_we && reg_addr == ADDR_CTRL && reg_wdata[CTL_EN])) begin
         start_conversion_q <= 1'b0;
      end else if (reg_we && reg_addr == ADDR_CTRL && reg_wdata[CTL_START]) begin
         start_conversion_q <= 1'b1;
      end else if (halt_start || trig_edge) begin
         start_conversion_q <= 1'b1;
      end else if (done_now && !free_restart) begin
         start_conversion_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // conversion sequence
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ACS_IDLE;
         hc_q <= 6'h00;
         first_q <= 1'b1;
         auto_conv_q <= 1'b0;
      end else if (!converter_enable_q) begin
         state_q <= ACS_IDLE;
         hc_q <= 6'h00;
         first_q <= 1'b1;
         auto_conv_q <= 1'b0;
      end else begin
         case (state_q)
            ACS_IDLE: begin
               hc_q <= 6'h00;
               if (conv_start) begin
                  state_q <= ACS_CONV;
                  auto_conv_q <= trig_edge && !first_q;
               end
            end
            ACS_CONV: begin
               if (done_now) begin
                  hc_q <= 6'h00;
                  first_q <= 1'b0;
                  auto_conv_q <= 1'b0;
                  state_q <= free_restart ? ACS_CONV : ACS_IDLE;
               end else if (pif.tick) begin
                  hc_q <= hc_q + 6'h01;
               end
            end
            default: state_q <= ACS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // sample and successive approximation
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sh_q <= 1'b0;
         sampled_q <= 1'b0;
         sar_q <= 10'h000;
         bit_q <= 10'h000;
      end else begin
         sh_q <= 1'b0;
         if (state_q != ACS_CONV || done_now) begin
            sampled_q <= 1'b0;
            sar_q <= 10'h000;
            bit_q <= 10'h000;
         end else if (pif.tick && !sampled_q && hc_q == sample_h - 6'h01) begin
            sh_q <= 1'b1;
            sampled_q <= 1'b1;
            sar_q <= SAR_TOP;
            bit_q <= SAR_TOP;
         end else if (pif.tick && bit_q != 10'h000) begin
            // comparator high means input above trial, keep the bit
            sar_q <= (cmp_s2_q ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
            bit_q <= bit_q >> 1;
         end
      end
   end

   // ----------------------------------------
   // active selection
   // ----------------------------------------
   // locked during a conversion so the sampling input cannot move
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ch_q <= 4'h0;
         ref_q <= 2'h0;
      end else if (state_q == ACS_IDLE && !conv_start || last_cycle) begin
         ch_q <= channel_reference_select_reg_q[SEL_CH_HI:0];
         ref_q <= channel_reference_select_reg_q[SEL_REF_HI:SEL_REF_LO];
      end
   end

   // ----------------------------------------
   // result, done flag and request
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         result_q <= 10'h000;
      end else if (done_now && !block_q) begin
         result_q <= sar_q;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         block_q <= 1'b0;
      end else if (reg_re && reg_addr == ADDR_RES_LO) begin
         block_q <= 1'b1;
      end else if (reg_re && reg_addr == ADDR_RES_HI) begin
         block_q <= 1'b0;
      end
   end

   // a completion in the clearing cycle keeps the flag set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         conversion_done_flag_q <= 1'b0;
      end else if (done_now) begin
         conversion_done_flag_q <= 1'b1;
      end else if (sw_clear_done) begin
         conversion_done_flag_q <= 1'b0;
      end
   end

   // request follows the flag, so a wake by another source does not lose it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (conversion_done_flag_q && !sw_clear_done || done_now) && irq_enable_q;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_q <= RST_BYTE;
      end else if (!reg_re) begin
         rdata_q <= RST_BYTE;
      end else begin
         case (reg_addr)
            ADDR_CTRL: rdata_q <= {converter_enable_q, start_conversion_q || state_q == ACS_CONV,
                                   auto_trigger_enable_q, conversion_done_flag_q, irq_enable_q,
                                   clock_divide_select_q};
            ADDR_SEL: rdata_q <= channel_reference_select_reg_q & 8'hEF;
            ADDR_RES_LO: rdata_q <= channel_reference_select_reg_q[SEL_LADJ] ?
                                    {result_q[1:0], 6'h00} : result_q[7:0];
            ADDR_RES_HI: rdata_q <= channel_reference_select_reg_q[SEL_LADJ] ?
                                    result_q[9:2] : {6'h00, result_q[9:8]};
            ADDR_TRIG: rdata_q <= {7'h00, free_run_q};
            default: rdata_q <= RST_BYTE;
         endcase
      end
   end

   assign reg_rdata = rdata_q;
   assign sample_hold = sh_q;
   assign dac_code = sar_q;
   assign channel_select = ch_q;
   assign reference_select = ref_q;
   assign analog_on = converter_enable_q;
   assign conv_irq = irq_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_start_edge;
      start_now && converter_enable_q |=> state_q == ACS_CONV && hc_q == 6'h00;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("start missed clock rise");

   property p_norm_len;
      done_now && !first_q && !auto_conv_q |-> hc_q == 6'h19 && sampled_q;
   endproperty
   a_norm_len: assert property (p_norm_len) else $error("normal length wrong");

   property p_first_len;
      done_now && first_q |-> hc_q == 6'h31;
   endproperty
   a_first_len: assert property (p_first_len) else $error("first length wrong");

   property p_sample_at;
      sh_q |-> (first_q ? hc_q == 6'h1B : (auto_conv_q ? hc_q == 6'h04 : hc_q == 6'h03));
   endproperty
   a_sample_at: assert property (p_sample_at) else $error("sample instant wrong");

   property p_done_single;
      done_now && !free_run_q |=> conversion_done_flag_q && !start_conversion_q;
   endproperty
   a_done_single: assert property (p_done_single) else $error("done effects wrong");

   property p_trig_clr;
      trig_edge |=> state_q == ACS_CONV && !pif.tick && hc_q == 6'h00;
   endproperty
   a_trig_clr: assert property (p_trig_clr) else $error("trigger start wrong");

   property p_free_run;
      free_restart && converter_enable_q |=> state_q == ACS_CONV && hc_q == 6'h00;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run stopped");

   property p_sel_lock;
      state_q == ACS_CONV && $past(state_q) == ACS_CONV && !$past(last_cycle)
         |-> $stable(ch_q) && $stable(ref_q);
   endproperty
   a_sel_lock: assert property (p_sel_lock) else $error("selection moved");

   property p_block;
      block_q && done_now |=> $stable(result_q) && conversion_done_flag_q;
   endproperty
   a_block: assert property (p_block) else $error("blocked result changed");

   property p_busy_ignore;
      state_q == ACS_CONV && trg_s2_q && !trg_s3_q |-> !pif.clr;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("edge during conversion");
endmodule

/* acs_pkg.sv */
// Purpose: shared constants for the converter sequencer
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: conversion timing is counted in conversion clock half cycles
package acs_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_SEL = 3'h1;
   localparam logic [2:0] ADDR_RES_LO = 3'h2;
   localparam logic [2:0] ADDR_RES_HI = 3'h3;
   localparam logic [2:0] ADDR_TRIG = 3'h4;
   // control/status fields
   localparam int CTL_EN = 7;
   localparam int CTL_START = 6;
   localparam int CTL_ATE = 5;
   localparam int CTL_DONE = 4;
   localparam int CTL_IE = 3;
   // selection fields
   localparam int SEL_REF_HI = 7;
   localparam int SEL_REF_LO = 6;
   localparam int SEL_LADJ = 5;
   localparam int SEL_CH_HI = 3;
   // trigger source field
   localparam int TRG_FREE = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // ----------------------------------------
   // timing, in conversion clock half cycles
   // ----------------------------------------
   localparam logic [5:0] NORM_TOTAL_H = 6'h1A;
   localparam logic [5:0] NORM_SAMPLE_H = 6'h03;
   localparam logic [5:0] FIRST_TOTAL_H = 6'h32;
   localparam logic [5:0] FIRST_SAMPLE_H = 6'h1B;
   localparam logic [5:0] AUTO_TOTAL_H = 6'h1B;
   localparam logic [5:0] AUTO_SAMPLE_H = 6'h04;
   localparam int RES_BITS = 10;
   localparam logic [9:0] SAR_TOP = 10'h200;
   localparam logic [9:0] RES_FULL = 10'h3FF;
   localparam logic [6:0] ONE7 = 7'h01;
   // ----------------------------------------
   // half period of the conversion clock in system cycles
   // ----------------------------------------
   function automatic logic [6:0] half_of(input logic [2:0] sel);
      logic [6:0] h;
      h = (sel == 3'h0) ? ONE7 : (ONE7 << (sel - 3'h1));
      return h;
   endfunction
endpackage

/* acs_presc_if.sv */
`timescale 1ns/100ps
// Purpose: link between sequencer and conversion clock prescaler
// Assumes: single clock domain
// Notes: tick marks each half edge, rise the rising ones
interface acs_presc_if;
   logic en;
   logic clr;
   logic [2:0] sel;
   logic tick;
   logic rise;
   modport seq (output en, output clr, output sel, input tick, input rise);
   modport presc (input en, input clr, input sel, output tick, output rise);
endinterface

/* acs_prescaler.sv */
`timescale 1ns/100ps
// Purpose: conversion clock prescaler as one-cycle enable pulses
// Assumes: sel stable while enabled
// Notes: divide ratios 2,2,4,8,16,32,64,128
module acs_prescaler import acs_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // sequencer side
   acs_presc_if.presc pif
);
   logic [6:0] cnt_q;
   logic phase_q;
   logic tick_q;
   logic rise_q;

   // ----------------------------------------
   // divider
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_q <= 7'h00;
         phase_q <= 1'b0;
         tick_q <= 1'b0;
         rise_q <= 1'b0;
      end else if (!pif.en || pif.clr) begin
         cnt_q <= 7'h00;
         phase_q <= 1'b0;
         tick_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         rise_q <= 1'b0;
         if (cnt_q == half_of(pif.sel) - ONE7) begin
            cnt_q <= 7'h00;
            phase_q <= ~phase_q;
            tick_q <= 1'b1;
            rise_q <= ~phase_q;
         end else begin
            cnt_q <= cnt_q + ONE7;
         end
      end
   end
   assign pif.tick = tick_q;
   assign pif.rise = rise_q;

   property p_presc_held;
      @(posedge clk_sys) disable iff (rst) !pif.en |=> !pif.tick && cnt_q == 7'h00;
   endproperty
   a_presc_held: assert property (p_presc_held) else $error("prescaler ran while off");
endmodule

/* acs_analog_model.sv */
// Purpose: behavioural analog core beside the sequencer
// Assumes: vin in LSB of the selected reference, may exceed it
// Notes: half-LSB comparator offset gives floor codes
`timescale 1ns/100ps
module acs_analog_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // sequencer side
   input wire logic sample_hold,
   input wire logic analog_on,
   input wire logic [3:0] channel_select,
   input wire logic [9:0] dac_code,
   output logic cmp_in,
   // bench side
   input wire logic [15:0][10:0] vin
);
   logic [10:0] held_q;
   logic tog_q;
   // ----------------------------------------
   // sample and compare
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         held_q <= 11'h000;
         tog_q <= 1'h0;
      end else begin
         tog_q <= ~tog_q;
         if (sample_hold) begin
            held_q <= vin[channel_select];
         end
      end
   end
   // powered down: no stable level to lean on
   assign cmp_in = analog_on ? ({held_q, 1'h1} > {1'h0, dac_code, 1'h0}) : tog_q;
endmodule

/* tb_acs_sequencer.sv */
// Purpose: self-checking bench for the conversion sequencer
// Assumes: register map and timing of acs_pkg
// Notes: start instants are windows, the prescaler phase is free
`timescale 1ns/100ps
module tb_acs_sequencer import acs_pkg::*; ;
   logic clk_sys = 1'h0;
   logic rst;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_we, reg_re, trig_in, sleep_halt, cmp_in, sample_hold, analog_on, conv_irq;
   logic [9:0] dac_code;
   logic [3:0] channel_select;
   logic [1:0] reference_select;
   logic [15:0][10:0] vin;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   int sh_cnt = 0;
   integer seed = 75;
   acs_sequencer uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .trig_in(trig_in), .sleep_halt(sleep_halt), .cmp_in(cmp_in),
      .sample_hold(sample_hold), .dac_code(dac_code), .channel_select(channel_select),
      .reference_select(reference_select), .analog_on(analog_on), .conv_irq(conv_irq));
   acs_analog_model u_core (.clk_sys(clk_sys), .rst(rst), .sample_hold(sample_hold),
      .analog_on(analog_on), .channel_select(channel_select), .dac_code(dac_code),
      .cmp_in(cmp_in), .vin(vin));
   // ----------------------------------------
   // clock, watchdog, sample counter
   // ----------------------------------------
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (sample_hold === 1'h1) sh_cnt <= sh_cnt + 1;
      if (cyc == 40000) begin
         failures++;
         end_sim();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_win(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi) begin
         failures++;
         $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask
   // ideal floor code, clipped above the reference
   function automatic logic [9:0] exp_code(input logic [10:0] v);
      return v[10] ? RES_FULL : v[9:0];
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_we <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_we <= 1'h0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_re <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_re <= 1'h0;
      #1 d = reg_rdata;
   endtask
   // bounded wait on sample pulse or completion request
   task automatic wait_sig(input bit irq, output int n);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while ((irq ? conv_irq : sample_hold) !== 1'h1 && n < 9000);
   endtask
   // one single-mode conversion on a random channel, or on channel 15 over the reference when sel is 7
   task automatic conv(input logic [2:0] sel, input bit first);
      int n, h, s;
      logic [3:0] ch;
      logic [9:0] r;
      logic [7:0] d;
      h = 1 << ((sel == 3'h0) ? 0 : int'(sel) - 1);
      s = first ? 27 * h : 3 * h;
      ch = (sel == 3'h7) ? 4'hF : 4'($random(seed));
      vin[ch] = (ch == 4'hF) ? 11'h7FF : {1'h0, 10'($random(seed))};
      r = exp_code(vin[ch]);
      // reference stays fixed, so no result needs discarding
      wr(ADDR_SEL, {4'h4, ch});
      wr(ADDR_CTRL, 8'hC8 | {5'h00, sel});
      wait_sig(1'h0, n);
      chk_win(n, s, s + 2 * h + 6);
      chk({channel_select, reference_select}, {ch, 2'h1});
      wait_sig(1'h1, n);
      chk_win(n, 23 * h - 2, 23 * h + 4);
      rd(ADDR_CTRL, d);
      chk(d[7:4], 4'h9);
      // fast conversion clocks give up resolution
      rd(ADDR_RES_LO, d);
      if (sel > 3'h2) chk(d, r[7:0]);
      rd(ADDR_RES_HI, d);
      if (sel > 3'h2) chk(d, {6'h00, r[9:8]});
      wr(ADDR_CTRL, 8'h98 | {5'h00, sel});
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] d;
      logic [9:0] old;
      int n, base;
      rst = 1'h1;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_we = 1'h0;
      reg_re = 1'h0;
      trig_in = 1'h0;
      sleep_halt = 1'h0;
      vin = '0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'h0;
      wr(3'h5, 8'hFF);
      for (int a = 0; a < 6; a++) begin
         rd(3'(a), d);
         chk(d, RST_BYTE);
      end
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_CTRL, {5'h00, 3'(s)});
         repeat (2) @(negedge clk_sys);
         chk(analog_on, 1'h0);
         wr(ADDR_CTRL, 8'h80 | {5'h00, 3'(s)});
         conv(3'(s), 1'h1);
         conv(3'(s), 1'h0);
      end
      // free running, channel changed after a completion
      wr(ADDR_CTRL, 8'h04);
      wr(ADDR_TRIG, 8'h01);
      wr(ADDR_SEL, 8'h41);
      wr(ADDR_CTRL, 8'hEC);
      wait_sig(1'h0, n);
      base = cyc;
      wait_sig(1'h1, n);
      wr(ADDR_SEL, 8'h42);
      @(negedge clk_sys);
      chk(channel_select, 4'h1);
      wait_sig(1'h0, n);
      chk_win(cyc - base, 208, 208);
      chk(channel_select, 4'h1);
      base = cyc;
      wait_sig(1'h0, n);
      chk_win(cyc - base, 208, 208);
      chk(channel_select, 4'h2);
      // pin trigger, held result and ignored edges
      wr(ADDR_CTRL, 8'h03);
      wr(ADDR_TRIG, 8'h00);
      vin[2] = {1'h0, 10'($random(seed))};
      old = vin[2][9:0];
      wr(ADDR_CTRL, 8'hBB);
      @(posedge clk_sys);
      trig_in <= 1'h1;
      wait_sig(1'h1, n);
      @(posedge clk_sys);
      trig_in <= 1'h0;
      wr(ADDR_CTRL, 8'hBB);
      rd(ADDR_RES_LO, d);
      chk(d, old[7:0]);
      vin[2] = ~vin[2];
      @(posedge clk_sys);
      trig_in <= 1'h1;
      wait_sig(1'h0, n);
      chk_win(n, 18, 22);
      @(posedge clk_sys);
      trig_in <= 1'h0;
      repeat (4) @(posedge clk_sys);
      // taken after the counter has seen the pulse just waited for
      base = sh_cnt;
      trig_in <= 1'h1;
      wait_sig(1'h1, n);
      repeat (300) @(negedge clk_sys);
      chk(16'(sh_cnt - base), 16'h0000);
      chk(conv_irq, 1'h1);
      rd(ADDR_RES_HI, d);
      chk(d, {6'h00, old[9:8]});
      rd(ADDR_RES_LO, d);
      chk(d, old[7:0]);
      rd(ADDR_RES_HI, d);
      @(posedge clk_sys);
      trig_in <= 1'h0;
      // halt in quiet sleep starts a conversion
      wr(ADDR_CTRL, 8'h9B);
      @(posedge clk_sys);
      sleep_halt <= 1'h1;
      wait_sig(1'h0, n);
      chk_win(n, 12, 26);
      wait_sig(1'h1, n);
      chk_win(n, 90, 96);
      chk(analog_on, 1'h1);
      @(posedge clk_sys);
      sleep_halt <= 1'h0;
      // left adjusted view of the last result, input over the reference
      old = exp_code(vin[2]);
      wr(ADDR_SEL, 8'h62);
      rd(ADDR_RES_LO, d);
      chk(d, {old[1:0], 6'h00});
      rd(ADDR_RES_HI, d);
      chk(d, old[9:2]);
      end_sim();
   end
endmodule
